// file: inc/kpi_cfg.svh
// Constants of the keyboard pin interrupt block
`ifndef KPI_CFG_SVH
`define KPI_CFG_SVH

`define KPI_ADDR_W     8
`define KPI_DATA_W     32
`define KPI_REG_W      8
`define KPI_PE_W       4

// Register indices; byte address is four times the index
`define KPI_IDX_D_SCR  6'h0C
`define KPI_IDX_D_IER  6'h0D
`define KPI_IDX_E_SCR  6'h0E
`define KPI_IDX_E_IER  6'h0F
`define KPI_IDX_SHIFT  2'b00

// One-hot select positions
`define KPI_SEL_W      4
`define KPI_SEL_D_SCR  0
`define KPI_SEL_D_IER  1
`define KPI_SEL_E_SCR  2
`define KPI_SEL_E_IER  3

// Status/control fields
`define KPI_SCR_MODE   0
`define KPI_SCR_MASK   1
`define KPI_SCR_ACK    2
`define KPI_SCR_PEND   3
`define KPI_SCR_RSVD   4'h0

// Port-E enable register fields
`define KPI_IER_EN_LO  0
`define KPI_IER_EN_HI  3
`define KPI_IER_PU_LO  4
`define KPI_IER_PU_HI  7

`define KPI_RST_VAL    8'h00
`define KPI_E_PAD      4'hF
`define KPI_RESP_OKAY  2'h0
`define KPI_RESP_SLVERR 2'h2

`endif

// file: inc/kpi_pkg.sv
// Types of the keyboard pin interrupt block
`include "kpi_cfg.svh"

package kpi_pkg;

    typedef struct packed {
        logic                    awvalid;
        logic [`KPI_ADDR_W-1:0]  awaddr;
        logic                    wvalid;
        logic [`KPI_DATA_W-1:0]  wdata;
        logic [3:0]              wstrb;
        logic                    bready;
        logic                    arvalid;
        logic [`KPI_ADDR_W-1:0]  araddr;
        logic                    rready;
    } kpi_axi_req_t;

    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [`KPI_DATA_W-1:0]  rdata;
        logic [1:0]              rresp;
    } kpi_axi_rsp_t;

    typedef struct packed {
        logic [`KPI_REG_W-1:0]   en;
        logic                    mask;
        logic                    mode;
        logic                    req;
        logic                    prev_low;
        logic                    acked;
    } kpi_chan_t;

    typedef struct packed {
        kpi_chan_t               chd;
        kpi_chan_t               che;
        logic [`KPI_PE_W-1:0]    pull_e;
        logic [`KPI_REG_W-1:0]   d_sync1;
        logic [`KPI_REG_W-1:0]   d_sync2;
        logic [`KPI_PE_W-1:0]    e_sync1;
        logic [`KPI_PE_W-1:0]    e_sync2;
        logic                    aw_got;
        logic [`KPI_ADDR_W-1:0]  waddr;
        logic                    w_got;
        logic [`KPI_REG_W-1:0]   wbyte;
        logic                    wlane;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [`KPI_DATA_W-1:0]  rdata;
        logic [1:0]              rresp;
    } kpi_state_t;

endpackage

// file: verilog/kpi_top.sv
// Keyboard pin interrupt channels for port D and port E, AXI4-Lite register slave
//
// The address map and the AXI4-Lite slave port were decided locally.
`include "kpi_cfg.svh"

module kpi_top (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    // Register bus
    input  wire kpi_pkg::kpi_axi_req_t   axi_req,
    output      kpi_pkg::kpi_axi_rsp_t   axi_rsp,
    // Keyboard pins, asynchronous
    input  wire logic [`KPI_REG_W-1:0]   portd_key_pin,
    input  wire logic [`KPI_PE_W-1:0]    porte_key_pin,
    // CPU vector fetch acknowledges, one-cycle pulses
    input  wire logic                    portd_vector_fetch,
    input  wire logic                    porte_vector_fetch,
    // CPU interrupt requests
    output      logic                    portd_irq,
    output      logic                    porte_irq,
    // Pad controls
    output      logic [`KPI_REG_W-1:0]   portd_pullup_en,
    output      logic [`KPI_PE_W-1:0]    porte_pullup_en,
    output      logic [`KPI_REG_W-1:0]   portd_force_input,
    output      logic [`KPI_PE_W-1:0]    porte_force_input
);

    kpi_pkg::kpi_state_t s_r;
    kpi_pkg::kpi_state_t s_nxt;

    // Address decode, one-hot; zero means unmapped
    function automatic logic [`KPI_SEL_W-1:0] kpi_sel(input logic [`KPI_ADDR_W-1:0] a);
        logic [`KPI_SEL_W-1:0] sel;
        sel = '0;
        sel[`KPI_SEL_D_SCR] = (a == {`KPI_IDX_D_SCR, `KPI_IDX_SHIFT});
        sel[`KPI_SEL_D_IER] = (a == {`KPI_IDX_D_IER, `KPI_IDX_SHIFT});
        sel[`KPI_SEL_E_SCR] = (a == {`KPI_IDX_E_SCR, `KPI_IDX_SHIFT});
        sel[`KPI_SEL_E_IER] = (a == {`KPI_IDX_E_IER, `KPI_IDX_SHIFT});
        return sel;
    endfunction

    // Status/control read image
    function automatic logic [`KPI_REG_W-1:0] kpi_scr(input kpi_pkg::kpi_chan_t c);
        logic [`KPI_REG_W-1:0] v;
        v = '0;
        v[`KPI_REG_W-1:`KPI_SCR_PEND+1] = `KPI_SCR_RSVD;
        v[`KPI_SCR_PEND] = c.req;
        v[`KPI_SCR_ACK] = 1'b0;
        v[`KPI_SCR_MASK] = c.mask;
        v[`KPI_SCR_MODE] = c.mode;
        return v;
    endfunction

    // Status/control write: only mask and sensitivity are stored; pending is read-only
    function automatic kpi_pkg::kpi_chan_t kpi_scr_wr(input kpi_pkg::kpi_chan_t c,
                                                      input logic [`KPI_REG_W-1:0] b);
        kpi_pkg::kpi_chan_t n;
        n = c;
        n.mask = b[`KPI_SCR_MASK];
        n.mode = b[`KPI_SCR_MODE];
        return n;
    endfunction

    // Read image of one register; unmapped addresses read zero
    function automatic logic [`KPI_DATA_W-1:0] kpi_rd_word(input logic [`KPI_SEL_W-1:0] sel,
                                                           input kpi_pkg::kpi_state_t st);
        logic [`KPI_DATA_W-1:0] w;
        w = '0;
        if (sel[`KPI_SEL_D_SCR]) begin
            w[`KPI_REG_W-1:0] = kpi_scr(st.chd);
        end
        if (sel[`KPI_SEL_D_IER]) begin
            w[`KPI_REG_W-1:0] = st.chd.en;
        end
        if (sel[`KPI_SEL_E_SCR]) begin
            w[`KPI_REG_W-1:0] = kpi_scr(st.che);
        end
        if (sel[`KPI_SEL_E_IER]) begin
            w[`KPI_REG_W-1:0] = {st.pull_e, st.che.en[`KPI_PE_W-1:0]};
        end
        return w;
    endfunction

    // One channel's request latch; the set term wins over an acknowledge in the same cycle.
    // In level mode an acknowledge that comes while a pin is still low is remembered,
    // so the request drops once the last enabled pin is high again, in either order.
    function automatic kpi_pkg::kpi_chan_t kpi_step(input kpi_pkg::kpi_chan_t c,
                                                    input logic [`KPI_REG_W-1:0] pins,
                                                    input logic ack);
        kpi_pkg::kpi_chan_t n;
        logic               any_low;
        logic               set;
        logic               ack_seen;
        n = c;
        any_low = |(c.en & ~pins);
        set = c.mode ? any_low : (any_low & ~c.prev_low);
        ack_seen = ack | (c.mode & c.acked);
        n.req = set | (c.req & ~ack_seen);
        n.acked = c.mode & any_low & ack_seen;
        n.prev_low = any_low;
        return n;
    endfunction

    always_comb begin
        logic [`KPI_SEL_W-1:0] wsel;
        logic [`KPI_SEL_W-1:0] rsel;
        logic                  ack_d;
        logic                  ack_e;
        s_nxt = s_r;
        wsel = kpi_sel(s_r.waddr);
        rsel = kpi_sel(axi_req.araddr);
        ack_d = portd_vector_fetch;
        ack_e = porte_vector_fetch;

        // Pins are asynchronous; the first stage feeds only the second
        s_nxt.d_sync1 = portd_key_pin;
        s_nxt.d_sync2 = s_r.d_sync1;
        s_nxt.e_sync1 = porte_key_pin;
        s_nxt.e_sync2 = s_r.e_sync1;

        // Address and data are captured separately so either may come first
        if (axi_req.awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.waddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wbyte = axi_req.wdata[`KPI_REG_W-1:0];
            s_nxt.wlane = axi_req.wstrb[0];
        end

        // Write commits only once the previous response has been taken
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (|wsel) ? `KPI_RESP_OKAY : `KPI_RESP_SLVERR;
            // Registers are one byte wide; a write without lane 0 changes nothing
            if (s_r.wlane) begin
                if (wsel[`KPI_SEL_D_SCR]) begin
                    s_nxt.chd = kpi_scr_wr(s_nxt.chd, s_r.wbyte);
                    ack_d = ack_d | s_r.wbyte[`KPI_SCR_ACK];
                end
                if (wsel[`KPI_SEL_D_IER]) begin
                    s_nxt.chd.en = s_r.wbyte;
                end
                if (wsel[`KPI_SEL_E_SCR]) begin
                    s_nxt.che = kpi_scr_wr(s_nxt.che, s_r.wbyte);
                    ack_e = ack_e | s_r.wbyte[`KPI_SCR_ACK];
                end
                if (wsel[`KPI_SEL_E_IER]) begin
                    s_nxt.che.en = {`KPI_E_PAD ^ `KPI_E_PAD,
                                    s_r.wbyte[`KPI_IER_EN_HI:`KPI_IER_EN_LO]};
                    s_nxt.pull_e = s_r.wbyte[`KPI_IER_PU_HI:`KPI_IER_PU_LO];
                end
            end
        end
        if (s_r.bvalid && axi_req.bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Read data is captured at acceptance and held until taken
        if (axi_req.arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = (|rsel) ? `KPI_RESP_OKAY : `KPI_RESP_SLVERR;
            s_nxt.rdata = kpi_rd_word(rsel, s_r);
        end else if (s_r.rvalid && axi_req.rready) begin
            s_nxt.rvalid = 1'b0;
        end

        s_nxt.chd = kpi_step(s_nxt.chd, s_r.d_sync2, ack_d);
        // Unused upper port-E positions are padded high so they never look low
        s_nxt.che = kpi_step(s_nxt.che, {`KPI_E_PAD, s_r.e_sync2}, ack_e);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        axi_rsp = '0;
        axi_rsp.awready = !s_r.aw_got;
        axi_rsp.wready = !s_r.w_got;
        axi_rsp.bvalid = s_r.bvalid;
        axi_rsp.bresp = s_r.bresp;
        axi_rsp.arready = !s_r.rvalid;
        axi_rsp.rvalid = s_r.rvalid;
        axi_rsp.rdata = s_r.rdata;
        axi_rsp.rresp = s_r.rresp;
    end

    assign portd_irq = s_r.chd.req & ~s_r.chd.mask;
    assign porte_irq = s_r.che.req & ~s_r.che.mask;
    assign portd_pullup_en = s_r.chd.en;
    assign porte_pullup_en = s_r.pull_e;
    assign portd_force_input = s_r.chd.en;
    assign porte_force_input = s_r.che.en[`KPI_PE_W-1:0];

endmodule

// file: tb/kpi_asserts.sv
// Port checks for the keyboard interrupt block
module kpi_asserts (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  resetn,
    // Register bus
    input wire kpi_pkg::kpi_axi_req_t axi_req,
    input wire kpi_pkg::kpi_axi_rsp_t axi_rsp,
    // Pins and CPU side
    input wire logic [7:0]            portd_key_pin,
    input wire logic [3:0]            porte_key_pin,
    input wire logic                  portd_vector_fetch,
    input wire logic                  porte_vector_fetch,
    input wire logic                  portd_irq,
    input wire logic                  porte_irq,
    // Pad controls
    input wire logic [7:0]            portd_pullup_en,
    input wire logic [3:0]            porte_pullup_en,
    input wire logic [7:0]            portd_force_input,
    input wire logic [3:0]            porte_force_input
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Four samples cover the two sync flops and the latch
    sequence s_d_idle;
        (&(portd_key_pin | ~portd_force_input))[*4];
    endsequence
    sequence s_e_idle;
        (&(porte_key_pin | ~porte_force_input))[*4];
    endsequence
    sequence s_wr;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready && !axi_rsp.bvalid;
    endsequence
    property p_rst; $rose(resetn) |-> !portd_irq && !porte_irq && portd_pullup_en == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("request or pull-up left after reset");
    property p_d_fetch; s_d_idle ##0 (portd_vector_fetch && $stable(portd_force_input)) |=> !portd_irq; endproperty
    a_d_fetch: assert property (p_d_fetch) else $error("port D fetch did not clear");
    property p_e_fetch; s_e_idle ##0 (porte_vector_fetch && $stable(porte_force_input)) |=> !porte_irq; endproperty
    a_e_fetch: assert property (p_e_fetch) else $error("port E fetch did not clear");
    // A commit edge may unmask or re-enable, so it is left out
    property p_cause; $rose(portd_irq) && !$rose(axi_rsp.bvalid) |-> |(~$past(portd_key_pin, 3) & portd_force_input); endproperty
    a_cause: assert property (p_cause) else $error("port D request without low pin");
    property p_force; portd_force_input == portd_pullup_en; endproperty
    a_force: assert property (p_force) else $error("port D pull-up differs from enable");
    property p_rd_hi; axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_b_hold; axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_ans; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_w_ans; s_wr |-> ##[1:2] axi_rsp.bvalid; endproperty
    a_w_ans: assert property (p_w_ans) else $error("write answer late");
endmodule

bind kpi_top kpi_asserts i_kpi_asserts (.clk_sys, .resetn, .axi_req, .axi_rsp, .portd_key_pin, .porte_key_pin,
    .portd_vector_fetch, .porte_vector_fetch, .portd_irq, .porte_irq, .portd_pullup_en, .porte_pullup_en,
    .portd_force_input, .porte_force_input);

// file: tb/kpi_keys.sv
// Switch and pad model on the keyboard pins
module kpi_keys (
    // Clock
    input  wire logic       clk_sys,
    // Switches closed by the bench, pad pull-ups
    input  wire logic [7:0] press_d,
    input  wire logic [3:0] press_e,
    input  wire logic [7:0] pull_d,
    input  wire logic [3:0] pull_e,
    // Pin levels
    output logic [7:0]      pin_d,
    output logic [3:0]      pin_e
);
    timeunit 1ns;
    timeprecision 100ps;
    // pin level without pull-up
    // Unpulled open pins float, so they show a changing pattern
    logic [7:0] flt_r = 8'h55;
    always @(posedge clk_sys) flt_r <= ~flt_r;
    assign pin_d = ~press_d & (pull_d | flt_r);
    assign pin_e = ~press_e & (pull_e | flt_r[3:0]);
endmodule

// file: tb/testbench.sv
// Self-checking bench for the keyboard interrupt block
`include "kpi_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] reg_addr [4] = '{{`KPI_IDX_D_SCR, 2'b00}, {`KPI_IDX_D_IER, 2'b00},
        {`KPI_IDX_E_SCR, 2'b00}, {`KPI_IDX_E_IER, 2'b00}};
    logic                  clk_sys = 1'b0;
    logic                  resetn = 1'b0;
    kpi_pkg::kpi_axi_req_t axi_req = '0;
    kpi_pkg::kpi_axi_rsp_t axi_rsp;
    logic [7:0]            pin_d, pu_d, fi_d, rnd;
    logic [7:0]            press_d = 8'h00;
    logic [3:0]            pin_e, pu_e, fi_e;
    logic [3:0]            press_e = 4'h0;
    logic                  vf_d = 1'b0, vf_e = 1'b0, irq_d, irq_e;
    logic [33:0]           exp_q [$];
    integer                bad_count = 0, samples_checked = 0, seed = 32'h10a495c2;
    always #2 clk_sys = ~clk_sys;
    kpi_top i_kpi_top (.clk_sys, .resetn, .axi_req, .axi_rsp, .portd_key_pin(pin_d), .porte_key_pin(pin_e),
        .portd_vector_fetch(vf_d), .porte_vector_fetch(vf_e), .portd_irq(irq_d), .porte_irq(irq_e),
        .portd_pullup_en(pu_d), .porte_pullup_en(pu_e), .portd_force_input(fi_d), .porte_force_input(fi_e));
    kpi_keys i_kpi_keys (.clk_sys, .press_d, .press_e, .pull_d(pu_d), .pull_e(pu_e), .pin_d, .pin_e);
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta = 1'b0, tw = 1'b0;
        axi_req.awaddr <= a;
        axi_req.wdata <= {24'h000000, d};
        axi_req.wstrb <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        // Ready seen before the edge equals ready at the edge
        do begin
            @(negedge clk_sys);
            if (axi_req.awvalid) ta = axi_rsp.awready;
            if (axi_req.wvalid) tw = axi_rsp.wready;
            @(posedge clk_sys);
            if (ta) axi_req.awvalid <= 1'b0;
            if (tw) axi_req.wvalid <= 1'b0;
        end while (!(ta && tw));
        do @(negedge clk_sys); while (axi_rsp.bvalid !== 1'b1);
        @(posedge clk_sys);
        axi_req.bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] rs = 2'h0);
        exp_q.push_back({rs, 24'h000000, e});
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do @(negedge clk_sys); while (axi_rsp.arready !== 1'b1);
        @(posedge clk_sys);
        axi_req.arvalid <= 1'b0;
        do @(negedge clk_sys); while (axi_rsp.rvalid !== 1'b1);
        @(posedge clk_sys);
        axi_req.rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic fetch(input logic d);
        if (d) vf_d <= 1'b1;
        else vf_e <= 1'b1;
        @(posedge clk_sys);
        vf_d <= 1'b0;
        vf_e <= 1'b0;
        cyc(2);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Read results are compared in order of issue
    always @(posedge clk_sys) begin
        if (axi_rsp.rvalid && axi_req.rready) chk({axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front());
    end
    initial begin
        #80000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        foreach (reg_addr[i]) rd(reg_addr[i], 8'h00);
        rd(8'h00, 8'h00, `KPI_RESP_SLVERR);
        done("reset values");
        wr(reg_addr[0], 8'hFF);
        rd(reg_addr[0], 8'h03);
        rnd = $random(seed);
        wr(reg_addr[1], rnd);
        rd(reg_addr[1], rnd);
        chk({18'h0, pu_d, fi_d}, {18'h0, rnd, rnd});
        rnd = $random(seed);
        wr(reg_addr[3], rnd);
        rd(reg_addr[3], rnd);
        chk({26'h0, pu_e, fi_e}, {26'h0, rnd});
        done("registers");
        wr(reg_addr[0], 8'h02);
        wr(reg_addr[1], 8'hFF);
        wr(reg_addr[0], 8'h06);
        wr(reg_addr[0], 8'h00);
        press_d <= 8'h08;
        cyc(5);
        rd(reg_addr[0], 8'h08);
        chk(irq_d, 1'b1);
        wr(reg_addr[0], 8'h04);
        rd(reg_addr[0], 8'h00);
        press_d <= 8'h28;
        cyc(5);
        rd(reg_addr[0], 8'h00);
        press_d <= 8'h00;
        cyc(3);
        press_d <= 8'h02;
        cyc(5);
        wr(reg_addr[0], 8'h02);
        rd(reg_addr[0], 8'h0A);
        chk(irq_d, 1'b0);
        press_d <= 8'h00;
        cyc(5);
        fetch(1'b1);
        rd(reg_addr[0], 8'h02);
        done("edge mode");
        // Level pins settle before the acknowledge
        wr(reg_addr[2], 8'h03);
        wr(reg_addr[3], 8'hFF);
        cyc(8);
        wr(reg_addr[2], 8'h07);
        wr(reg_addr[2], 8'h01);
        press_e <= 4'h4;
        cyc(5);
        rd(reg_addr[2], 8'h09);
        chk(irq_e, 1'b1);
        wr(reg_addr[2], 8'h05);
        rd(reg_addr[2], 8'h09);
        press_e <= 4'h0;
        cyc(5);
        rd(reg_addr[2], 8'h01);
        press_e <= 4'h1;
        cyc(5);
        press_e <= 4'h0;
        cyc(5);
        rd(reg_addr[2], 8'h09);
        fetch(1'b0);
        rd(reg_addr[2], 8'h01);
        done("level mode");
        wr(reg_addr[0], 8'h01);
        press_d <= 8'h01;
        cyc(5);
        rd(reg_addr[0], 8'h09);
        resetn <= 1'b0;
        cyc(4);
        resetn <= 1'b1;
        rd(reg_addr[0], 8'h00);
        rd(reg_addr[1], 8'h00);
        done("second reset");
        print_verdict;
    end
endmodule
